// *** logic/scan_status_pkg.sv ***
/*
 * constants for the scanner status readout register group.
 * assumes a byte-wide register port with addresses in the low bits.
 */
package scan_status_pkg;
   // =====================================================================
   // register offsets
   localparam logic [7:0] ADDR_IMAGE_BYTE = 8'h00;
   localparam logic [7:0] ADDR_FILL_LEVEL = 8'h01;
   localparam logic [7:0] ADDR_STATUS = 8'h02;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h03;
   localparam logic [7:0] ADDR_EDGE_CFG = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h05;
   // =====================================================================
   // status flag bit positions
   localparam int BIT_SENSE_ONE = 0;
   localparam int BIT_SENSE_TWO = 1;
   localparam int BIT_MISC_ONE = 2;
   localparam int BIT_MISC_TWO = 3;
   localparam int BIT_PAUSE = 4;
   localparam int BIT_POWER_DIP = 5;
   // =====================================================================
   // reset values and widths
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [3:0] EDGE_CFG_RESET = 4'h0;
   localparam logic [5:0] IRQ_MASK_RESET = 6'h00;
   localparam int INPUT_COUNT = 4;
   localparam int EVENT_COUNT = 6;
endpackage : scan_status_pkg

// *** logic/scanner_status_readout.sv ***
/*
 * scanner status readout: image byte port, fill level, status flags,
 * an event status/mask pair and one level interrupt.
 * assumes the image buffer presents a byte with valid/ready and a count,
 * and the inputs are synchronous to CLOCK_I.
 */
`timescale 1ns/1ps
module scanner_status_readout #(
   parameter int COUNT_WIDTH = 8
) (
   input wire logic CLOCK_I, // system clock, 20 MHz
   input wire logic RESETN_I, // async reset, active low
   input wire logic [7:0] ADDR_I, // register address
   input wire logic [7:0] WDATA_I, // write data
   input wire logic WR_I, // write strobe
   input wire logic RD_I, // read strobe
   output logic [7:0] RDATA_O, // read data, one cycle after strobe
   input wire logic [7:0] IMG_DATA_I, // image buffer head byte
   input wire logic IMG_VALID_I, // image buffer head byte valid
   output logic IMG_POP_O, // one-cycle pop of the head byte
   input wire logic [COUNT_WIDTH-1:0] IMG_COUNT_I, // bytes waiting in buffer
   input wire logic PAPER_SENSE_ONE_I, // paper sensor one level
   input wire logic PAPER_SENSE_TWO_I, // paper sensor two level
   input wire logic MISC_ONE_I, // general-purpose pin one level
   input wire logic MISC_TWO_I, // general-purpose pin two level
   input wire logic PAUSE_EVENT_I, // pulse: pause/reverse entered on full buffer
   input wire logic LINE_START_I, // pulse: new line processing begins
   input wire logic POWER_DIP_I, // supply below 3V indication
   output logic IRQ_O // level interrupt
);
   // =====================================================================
   // parameter check
   // the read data path is one byte wide, so a wider count cannot be shown
   if (COUNT_WIDTH < 1 || COUNT_WIDTH > 8) begin : gen_bad_count_width
      $error("COUNT_WIDTH must be 1..8");
   end

   // =====================================================================
   // reset release through two flip-flops
   logic rst_meta_reg;
   logic rst_n;
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // =====================================================================
   // access decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   logic rd_image, rd_status, rd_irq_status, wr_mask, wr_edge;
   assign rd_image = RD_I && hit(ADDR_I, scan_status_pkg::ADDR_IMAGE_BYTE);
   assign rd_status = RD_I && hit(ADDR_I, scan_status_pkg::ADDR_STATUS);
   assign rd_irq_status = RD_I && hit(ADDR_I, scan_status_pkg::ADDR_IRQ_STATUS);
   assign wr_mask = WR_I && hit(ADDR_I, scan_status_pkg::ADDR_IRQ_MASK);
   assign wr_edge = WR_I && hit(ADDR_I, scan_status_pkg::ADDR_EDGE_CFG);

   // =====================================================================
   // sticky flag helper
   // one rule for every flag that an event sets and a read clears:
   // when both fall in one cycle the set wins, so no event slips past a read
   function automatic logic sticky(input logic cur, input logic clr, input logic set);
      sticky = (cur && !clr) || set;
   endfunction : sticky

   // =====================================================================
   // pin sampling and rising-edge detection
   logic [scan_status_pkg::INPUT_COUNT-1:0] in_now;
   logic [scan_status_pkg::INPUT_COUNT-1:0] in_prev_reg;
   logic [scan_status_pkg::INPUT_COUNT-1:0] in_prev_next;
   logic [scan_status_pkg::INPUT_COUNT-1:0] rise;

   // pins gathered in status-bit order, edges against last cycle's levels
   always_comb begin
      in_now = '0;
      in_now[scan_status_pkg::BIT_SENSE_ONE] = PAPER_SENSE_ONE_I;
      in_now[scan_status_pkg::BIT_SENSE_TWO] = PAPER_SENSE_TWO_I;
      in_now[scan_status_pkg::BIT_MISC_ONE] = MISC_ONE_I;
      in_now[scan_status_pkg::BIT_MISC_TWO] = MISC_TWO_I;
      in_prev_next = in_now;
      rise = in_now & ~in_prev_reg;
   end

   // previous levels start low, the idle level of the pins, so a pin that is high
   // at reset release reports one edge in the first cycle
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         in_prev_reg <= '0;
      end else begin
         in_prev_reg <= in_prev_next;
      end
   end

   // =====================================================================
   // edge latches for edge-sensitive inputs
   logic [scan_status_pkg::INPUT_COUNT-1:0] latch_reg;
   logic [scan_status_pkg::INPUT_COUNT-1:0] latch_next;

   // a rising edge sets the latch, a status read clears all of them
   // a latch whose input is in level mode keeps catching edges but is not shown
   always_comb begin
      latch_next = latch_reg;
      for (int i = 0; i < scan_status_pkg::INPUT_COUNT; i++) begin
         latch_next[i] = sticky(latch_reg[i], rd_status, rise[i]);
      end
   end

   // latch registers
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         latch_reg <= '0;
      end else begin
         latch_reg <= latch_next;
      end
   end

   // =====================================================================
   // software configuration: edge select and interrupt mask
   logic [scan_status_pkg::INPUT_COUNT-1:0] edge_cfg_reg;
   logic [scan_status_pkg::INPUT_COUNT-1:0] edge_cfg_next;
   logic [scan_status_pkg::EVENT_COUNT-1:0] mask_reg;
   logic [scan_status_pkg::EVENT_COUNT-1:0] mask_next;

   // only the low bits of a write land; the rest read back as zero
   // writes to the read-only addresses fall through the decode and are dropped
   always_comb begin
      edge_cfg_next = edge_cfg_reg;
      mask_next = mask_reg;
      if (wr_edge) begin
         edge_cfg_next = WDATA_I[scan_status_pkg::INPUT_COUNT-1:0];
      end
      if (wr_mask) begin
         mask_next = WDATA_I[scan_status_pkg::EVENT_COUNT-1:0];
      end
   end

   // configuration registers, level mode and all events masked after reset
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         edge_cfg_reg <= scan_status_pkg::EDGE_CFG_RESET;
         mask_reg <= scan_status_pkg::IRQ_MASK_RESET;
      end else begin
         edge_cfg_reg <= edge_cfg_next;
         mask_reg <= mask_next;
      end
   end

   // =====================================================================
   // pause bit
   logic pause_reg;
   logic pause_next;

   // set when the scanner pauses on a full buffer, cleared when a new line starts;
   // a pause in the first cycle of a line belongs to that line, so the set wins
   always_comb begin
      pause_next = sticky(pause_reg, LINE_START_I, PAUSE_EVENT_I);
   end

   // pause register; a status read leaves it alone
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         pause_reg <= 1'b0;
      end else begin
         pause_reg <= pause_next;
      end
   end

   // =====================================================================
   // supply dip flag
   logic dip_reg;
   logic dip_next;

   // held from the first dip until a status read; a dip in the read cycle
   // is kept for the next read rather than lost
   // a supply that stays low for many cycles simply keeps the flag set
   always_comb begin
      dip_next = sticky(dip_reg, rd_status, POWER_DIP_I);
   end

   // dip register
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         dip_reg <= 1'b0;
      end else begin
         dip_reg <= dip_next;
      end
   end

   // =====================================================================
   // interrupt status: one sticky bit per event, same layout as the status byte
   logic [scan_status_pkg::EVENT_COUNT-1:0] events;
   logic [scan_status_pkg::EVENT_COUNT-1:0] irq_stat_reg;
   logic [scan_status_pkg::EVENT_COUNT-1:0] irq_stat_next;

   // edges, the pause entry and the supply dip are the events; reading the
   // interrupt status clears it, an event in that cycle survives
   // unmasked bits drive the interrupt line below
   always_comb begin
      events = '0;
      events[scan_status_pkg::INPUT_COUNT-1:0] = rise;
      events[scan_status_pkg::BIT_PAUSE] = PAUSE_EVENT_I;
      events[scan_status_pkg::BIT_POWER_DIP] = POWER_DIP_I;
      irq_stat_next = irq_stat_reg;
      for (int i = 0; i < scan_status_pkg::EVENT_COUNT; i++) begin
         irq_stat_next[i] = sticky(irq_stat_reg[i], rd_irq_status, events[i]);
      end
   end

   // interrupt status register
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_reg <= '0;
      end else begin
         irq_stat_reg <= irq_stat_next;
      end
   end

   // =====================================================================
   // read data, image pop and interrupt line
   logic [scan_status_pkg::INPUT_COUNT-1:0] in_view;
   logic [7:0] status_byte;
   logic [7:0] rdata_next;
   logic pop_next;
   logic irq_next;

   // status byte: edge-sensitive inputs show their latch, level ones the live pin
   always_comb begin
      in_view = (edge_cfg_reg & latch_reg) | (~edge_cfg_reg & in_now);
      status_byte = scan_status_pkg::ZERO_BYTE;
      status_byte[scan_status_pkg::INPUT_COUNT-1:0] = in_view;
      status_byte[scan_status_pkg::BIT_PAUSE] = pause_reg;
      status_byte[scan_status_pkg::BIT_POWER_DIP] = dip_reg;
   end

   // one byte answered per read strobe; the bus shows zero in every other cycle
   // the fill count is passed through as it stands; it can move between two
   // reads, which is why software reads it twice and waits for agreement
   always_comb begin
      rdata_next = scan_status_pkg::ZERO_BYTE;
      if (RD_I) begin
         case (ADDR_I)
            scan_status_pkg::ADDR_IMAGE_BYTE: begin
               rdata_next = IMG_DATA_I;
            end
            scan_status_pkg::ADDR_FILL_LEVEL: begin
               rdata_next = 8'(IMG_COUNT_I);
            end
            scan_status_pkg::ADDR_STATUS: begin
               rdata_next = status_byte;
            end
            scan_status_pkg::ADDR_IRQ_MASK: begin
               rdata_next = 8'(mask_reg);
            end
            scan_status_pkg::ADDR_EDGE_CFG: begin
               rdata_next = 8'(edge_cfg_reg);
            end
            scan_status_pkg::ADDR_IRQ_STATUS: begin
               rdata_next = 8'(irq_stat_reg);
            end
            default: begin
               rdata_next = scan_status_pkg::ZERO_BYTE;
            end
         endcase
      end
   end

   // the head byte is consumed only when it was valid; the pop reaches the buffer
   // one cycle after the read, so two reads of the image byte need a gap of one
   // cycle or the second one sees the same byte again
   // the line is high while an unmasked status bit is set, taken from the next
   // values so that it changes in step with the status register
   always_comb begin
      pop_next = rd_image && IMG_VALID_I;
      irq_next = |(irq_stat_next & mask_next);
   end

   // every output leaves from a flip-flop
   // reset drives every output low, the idle value of the bus
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         RDATA_O <= scan_status_pkg::ZERO_BYTE;
         IMG_POP_O <= 1'b0;
         IRQ_O <= 1'b0;
      end else begin
         RDATA_O <= rdata_next;
         IMG_POP_O <= pop_next;
         IRQ_O <= irq_next;
      end
   end
endmodule : scanner_status_readout

// *** sim/img_buffer_model.sv ***
/* image buffer model: three bytes queued at reset.
   assumes pop is a one-cycle pulse on the same clock. */
`timescale 1ns/1ps
module img_buffer_model (
   input wire logic clk_i, // clock
   input wire logic rst_n_i, // reset
   input wire logic pop_i, // pop
   output logic [7:0] data_o, // head
   output logic valid_o, // valid
   output logic [7:0] count_o // waiting
);
   logic [7:0] idx_reg;
   // =====
   // head advances on pop; an empty head shows an inverted pattern
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) idx_reg <= 8'h00;
      else if (pop_i && valid_o) idx_reg <= idx_reg + 8'h01;
   end
   assign valid_o = idx_reg < 8'h03;
   assign count_o = 8'h03 - idx_reg;
   assign data_o = valid_o ? 8'ha0 + idx_reg : ~(8'ha0 + idx_reg);
endmodule : img_buffer_model

// *** sim/scan_readout_checker.sv ***
/* checker: port assertions for the status readout.
   assumes a bind onto scanner_status_readout. */
`timescale 1ns/1ps
module scan_readout_checker #(
   parameter int COUNT_WIDTH = 8
) (
   input wire logic CLOCK_I, // clock
   input wire logic RESETN_I, // reset
   input wire logic [7:0] ADDR_I, // address
   input wire logic [7:0] WDATA_I, // wdata
   input wire logic WR_I, // write
   input wire logic RD_I, // read
   input wire logic [7:0] RDATA_O, // rdata
   input wire logic [7:0] IMG_DATA_I, // head
   input wire logic IMG_VALID_I, // valid
   input wire logic IMG_POP_O, // pop
   input wire logic [COUNT_WIDTH-1:0] IMG_COUNT_I, // count
   input wire logic PAPER_SENSE_ONE_I, // sense 1
   input wire logic PAPER_SENSE_TWO_I, // sense 2
   input wire logic MISC_ONE_I, // misc 1
   input wire logic MISC_TWO_I, // misc 2
   input wire logic PAUSE_EVENT_I, // pause
   input wire logic LINE_START_I, // line
   input wire logic POWER_DIP_I // dip
);
   logic [3:0] edge_reg;
   logic [3:0] edge_next;
   wire rd2 = RD_I && ADDR_I == 8'h02;
   // =====
   // edge config mirror, so live-level reads are checked only in level mode
   always_comb edge_next = (WR_I && ADDR_I == 8'h04) ? WDATA_I[3:0] : edge_reg;
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) edge_reg <= 4'h0;
      else edge_reg <= edge_next;
   end
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RESETN_I);
   a_image_pop: assert property (RD_I && ADDR_I == 8'h00 && IMG_VALID_I
      |=> IMG_POP_O && RDATA_O == $past(IMG_DATA_I)) else $error("image read wrong");
   a_pop_gated: assert property (!(RD_I && ADDR_I == 8'h00 && IMG_VALID_I) |=> !IMG_POP_O)
      else $error("pop without valid image read");
   a_fill_count: assert property (RD_I && ADDR_I == 8'h01
      |=> RDATA_O == $past(IMG_COUNT_I)) else $error("fill count wrong");
   a_live_levels: assert property (rd2 && edge_reg == 4'h0
      |=> RDATA_O[3:0] == $past({MISC_TWO_I, MISC_ONE_I, PAPER_SENSE_TWO_I, PAPER_SENSE_ONE_I}))
      else $error("level bits wrong");
   a_pause_seen: assert property (PAUSE_EVENT_I ##1 !LINE_START_I ##1 rd2 |=> RDATA_O[4])
      else $error("pause bit missing");
   a_dip_seen: assert property (POWER_DIP_I ##1 !rd2 ##1 rd2 |=> RDATA_O[5])
      else $error("dip flag missing");
   a_dip_clear: assert property (rd2 && !POWER_DIP_I ##1 !POWER_DIP_I ##1 rd2 && !POWER_DIP_I
      |=> !RDATA_O[5]) else $error("dip flag not cleared");
   cover property (IMG_POP_O);
   cover property (rd2 ##1 RDATA_O[5]);
   cover property (rd2 ##1 RDATA_O[0]);
endmodule : scan_readout_checker
bind scanner_status_readout scan_readout_checker #(.COUNT_WIDTH(COUNT_WIDTH)) chk (.*);

// *** sim/scanner_status_readout_tb_top.sv ***
/* testbench: register reads, events and interrupt of the readout.
   assumes the image buffer model on the far side. */
`timescale 1ns/1ps
module scanner_status_readout_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [3:0] lv = 4'h0; // misc2 misc1 sense2 sense1
   logic [2:0] ev = 3'h0; // dip line pause
   logic [7:0] rdata, img_data, img_count;
   logic img_valid, img_pop, irq;
   int errors = 0;
   int num_checks = 0;
   // =====
   always #25 clk = ~clk;
   img_buffer_model bufm (.clk_i(clk), .rst_n_i(rst_n), .pop_i(img_pop), .data_o(img_data),
      .valid_o(img_valid), .count_o(img_count));
   scanner_status_readout uut (.CLOCK_I(clk), .RESETN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IMG_DATA_I(img_data), .IMG_VALID_I(img_valid),
      .IMG_POP_O(img_pop), .IMG_COUNT_I(img_count), .PAPER_SENSE_ONE_I(lv[0]), .PAPER_SENSE_TWO_I(lv[1]),
      .MISC_ONE_I(lv[2]), .MISC_TWO_I(lv[3]), .PAUSE_EVENT_I(ev[0]), .LINE_START_I(ev[1]),
      .POWER_DIP_I(ev[2]), .IRQ_O(irq));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   // read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask : rd_reg
   task automatic pulse(input logic [2:0] e);
      @(posedge clk) ev <= e;
      @(posedge clk) ev <= 3'h0;
   endtask : pulse
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   initial begin
      repeat (2000) @(posedge clk);
      errors++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      wr_reg(8'h03, 8'h20);
      pulse(3'h4);
      rd_reg(8'h02, 8'h20);
      chk({7'h00, irq}, 8'h01);
      rd_reg(8'h02, 8'h00);
      rd_reg(8'h05, 8'h20);
      chk({7'h00, irq}, 8'h00);
      pulse(3'h1);
      rd_reg(8'h02, 8'h10);
      rd_reg(8'h02, 8'h10);
      chk({7'h00, irq}, 8'h00);
      pulse(3'h2);
      rd_reg(8'h02, 8'h00);
      rd_reg(8'h01, 8'h03);
      rd_reg(8'h01, 8'h03);
      rd_reg(8'h00, 8'ha0);
      rd_reg(8'h00, 8'ha1);
      rd_reg(8'h01, 8'h01);
      rd_reg(8'h00, 8'ha2);
      rd_reg(8'h00, 8'h5c);
      rd_reg(8'h40, 8'h00);
      @(posedge clk) lv <= 4'h9;
      rd_reg(8'h02, 8'h09);
      @(posedge clk) lv <= 4'h6;
      rd_reg(8'h02, 8'h06);
      wr_reg(8'h04, 8'h01);
      @(posedge clk) lv <= 4'h7;
      @(posedge clk) lv <= 4'h6;
      rd_reg(8'h02, 8'h07);
      rd_reg(8'h02, 8'h06);
      summarize();
   end
endmodule : scanner_status_readout_tb_top
